// *** front_panel_regs.svh ***
// Register offsets, reset values and timing counts for the front panel logic
// Overview of operation
// - Prev and next buttons step the selection backward or forward through the controls.
// - The LED of the selected control blinks while it stays selected.
// - Right arrow increases or advances the value; left arrow decreases it.
// - Left and right held together restore the selected control to default; on position only the horizontal part.
// - On position, left+right zeroes horizontal; up+down zeroes vertical position.
// - Control LED green at default value, orange when value differs.
// - A held arrow repeats changes at a rate that rises until it reaches a fixed maximum.
// - Standard lamp shows NTSC or PAL in green; the key selects it.
// - Mode lamp shows SD, HD or 3G high definition in green.
// - HD format offers 1080i, 720p, 1080p, segmented frame; selected lit green.
// - Audio gain indicator green at unity, orange above or below.
// - Audio level lamp green below, yellow near, red above peak threshold.
// - Input lamp green only while a valid computer input is detected.
// - Reference lamp green only while reference present and timing locked.
// - Position sets upper-left corner, size sets lower-right, via four arrows.
// - On size, up+down or left+right restores the largest region size.
// - Both SDI outputs carry identical video except with 3G level B mapping.
// - Composite follows SD picture in SD, outputs black in any HD mode.
// - Digital audio mode: left stream feeds channels 1/2, right feeds 3/4.
// - Output timing offset defaults to zero, adjustable; no reference needed.
`ifndef FRONT_PANEL_REGS_SVH
`define FRONT_PANEL_REGS_SVH

`define FP_CLK_HZ        125000000
`define FP_DEBOUNCE_MS   10
`define FP_CHORD_MS      50
`define FP_REP_START_MS  300
`define FP_REP_MIN_MS    20
`define FP_BLINK_MS      250
`define FP_DEBOUNCE_CYC  (`FP_CLK_HZ / 1000 * `FP_DEBOUNCE_MS)
`define FP_CHORD_CYC     (`FP_CLK_HZ / 1000 * `FP_CHORD_MS)
`define FP_REP_START_CYC (`FP_CLK_HZ / 1000 * `FP_REP_START_MS)
`define FP_REP_MIN_CYC   (`FP_CLK_HZ / 1000 * `FP_REP_MIN_MS)
`define FP_BLINK_CYC     (`FP_CLK_HZ / 1000 * `FP_BLINK_MS)

`define FP_OFS_SEL       8'h00
`define FP_OFS_POS       8'h04
`define FP_OFS_SIZE      8'h08
`define FP_OFS_TIMING    8'h0c
`define FP_OFS_CFG       8'h10
`define FP_OFS_THRESH    8'h14
`define FP_OFS_STATUS    8'h18
`define FP_OFS_VAL_BASE  8'h40

`define FP_POS_H_LSB     0
`define FP_POS_V_LSB     16
`define FP_CFG_LEVELB    0
`define FP_CFG_AUDDIG    1
`define FP_THR_NEAR_LSB  0
`define FP_THR_PEAK_LSB  16

`define FP_H_MAX         12'h77f
`define FP_V_MAX         12'h4af
`define FP_THR_NEAR_RST  16'h6000
`define FP_THR_PEAK_RST  16'h7800
`define FP_NUM_CTRL      11

`endif

// *** front_panel_pkg.sv ***
// Types shared by the front panel control logic
package front_panel_pkg;

  typedef enum logic [3:0] {
    CTRL_ASPECT = 4'b0000,
    CTRL_POS    = 4'b0001,
    CTRL_SIZE   = 4'b0010,
    CTRL_BORDER = 4'b0011,
    CTRL_SHARP  = 4'b0100,
    CTRL_BARS   = 4'b0101,
    CTRL_STD    = 4'b0110,
    CTRL_MODE   = 4'b0111,
    CTRL_FMT    = 4'b1000,
    CTRL_VGAIN  = 4'b1001,
    CTRL_AGAIN  = 4'b1010
  } ctrl_t;

  typedef enum logic [1:0] {
    MODE_SD = 2'b00,
    MODE_HD = 2'b01,
    MODE_3G = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    FMT_1080I = 2'b00,
    FMT_720P  = 2'b01,
    FMT_1080P = 2'b10,
    FMT_SEGMENTED_FRAME = 2'b11
  } fmt_t;

  typedef enum logic [1:0] {
    ARW_IDLE  = 2'b00,
    ARW_WAIT  = 2'b01,
    ARW_HOLD  = 2'b10,
    ARW_LATCH = 2'b11
  } arrow_state_t;

endpackage : front_panel_pkg

// *** front_panel_control_logic.sv ***
// Front panel buttons, control values, LEDs, status lamps and output routing
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "front_panel_regs.svh"

module front_panel_control_logic #(
  parameter int unsigned DEBOUNCE_CYC  = `FP_DEBOUNCE_CYC,
  parameter int unsigned CHORD_CYC     = `FP_CHORD_CYC,
  parameter int unsigned REP_START_CYC = `FP_REP_START_CYC,
  parameter int unsigned REP_MIN_CYC   = `FP_REP_MIN_CYC,
  parameter int unsigned BLINK_CYC     = `FP_BLINK_CYC
) (
  input  wire logic        SYS_CLK,        // 125 MHz system clock
  input  wire logic        RST,            // Synchronous reset, active high
  input  wire logic        WB_CYC_I,       // Wishbone cycle
  input  wire logic        WB_STB_I,       // Wishbone strobe
  input  wire logic        WB_WE_I,        // Wishbone write enable
  input  wire logic [7:0]  WB_ADR_I,       // Wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,       // Wishbone byte selects
  input  wire logic [31:0] WB_DAT_I,       // Wishbone write data
  output logic      [31:0] WB_DAT_O,       // Wishbone read data
  output logic             WB_ACK_O,       // Wishbone acknowledge
  input  wire logic        BTN_PREV,       // Step back button, high pressed
  input  wire logic        BTN_NEXT,       // Step forward button
  input  wire logic        BTN_UP,         // Up arrow
  input  wire logic        BTN_DOWN,       // Down arrow
  input  wire logic        BTN_LEFT,       // Left arrow
  input  wire logic        BTN_RIGHT,      // Right arrow
  input  wire logic        INPUT_VALID,    // Valid DVI or VGA input detected
  input  wire logic        REF_PRESENT,    // Valid reference present
  input  wire logic        REF_LOCKED,     // Output timing locked to reference
  input  wire logic [15:0] AUDIO_LEVEL,    // Peak level of output channels 1 and 2
  output logic [10:0]      CTRL_LED_GRN,   // Control LED green die, per control
  output logic [10:0]      CTRL_LED_RED,   // Control LED red die; both lit is orange
  output logic             STD_NTSC_LED,   // NTSC selected, green
  output logic             STD_PAL_LED,    // PAL selected, green
  output logic [2:0]       MODE_LED,       // SD, HD, 3G lamps, green
  output logic [3:0]       FMT_LED,        // 1080i, 720p, 1080p, segmented frame
  output logic             AGAIN_LED_GRN,  // Audio gain lamp green die
  output logic             AGAIN_LED_RED,  // Audio gain lamp red die
  output logic             LVL_LED_GRN,    // Audio level below threshold
  output logic             LVL_LED_YEL,    // Audio level approaching threshold
  output logic             LVL_LED_RED,    // Audio level above threshold
  output logic             INPUT_LED,      // Input lamp, green
  output logic             REF_LED,        // Reference lamp, green
  output logic             SDI2_MIRROR,    // SDI out 2 copies SDI out 1
  output logic             CPST_BLACK,     // Composite output forced to black
  output logic             AUD_RIGHT_TO_34,// Right input stream feeds channels 3/4
  output logic             FREE_RUN,       // Output timing runs without reference
  output logic [11:0]      REGION_X0,      // Selection upper-left horizontal
  output logic [11:0]      REGION_Y0,      // Selection upper-left vertical
  output logic [11:0]      REGION_X1,      // Selection lower-right horizontal
  output logic [11:0]      REGION_Y1,      // Selection lower-right vertical
  output logic [23:0]      TIMING_OFFSET   // Output timing offset from reference
);

  localparam int NCTRL = `FP_NUM_CTRL;
  localparam logic [7:0] VAL_DEF [NCTRL] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
                                             8'h00, 8'h01, 8'h00, 8'h80, 8'h80};
  localparam logic [7:0] VAL_MAX [NCTRL] = '{8'h03, 8'h00, 8'h00, 8'hff, 8'hff, 8'h01,
                                             8'h01, 8'h02, 8'h03, 8'hff, 8'hff};

  // Debounce: raw order is prev, next, up, down, left, right
  logic [5:0]  raw;
  logic [5:0]  deb_reg;
  logic [5:0]  deb_prev_reg;
  assign raw = {BTN_RIGHT, BTN_LEFT, BTN_DOWN, BTN_UP, BTN_NEXT, BTN_PREV};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_deb
      logic [31:0] cnt_reg;
      always_ff @(posedge SYS_CLK)
      begin
        if (RST)
        begin
          cnt_reg     <= 32'h0;
          deb_reg[gi] <= 1'b0;
        end
        else if (raw[gi] == deb_reg[gi])
          cnt_reg <= 32'h0;
        else if (cnt_reg >= DEBOUNCE_CYC - 1)
        begin
          cnt_reg     <= 32'h0;
          deb_reg[gi] <= raw[gi];
        end
        else
          cnt_reg <= cnt_reg + 32'h1;
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      deb_prev_reg <= 6'h00;
    else
      deb_prev_reg <= deb_reg;
  end

  logic prev_press;
  logic next_press;
  logic [3:0] arrows;
  logic chord_lr;
  logic chord_ud;
  assign prev_press = deb_reg[0] & ~deb_prev_reg[0];
  assign next_press = deb_reg[1] & ~deb_prev_reg[1];
  assign arrows     = deb_reg[5:2];
  assign chord_lr   = arrows[3] & arrows[2];
  assign chord_ud   = arrows[1] & arrows[0];

  // Selected control
  front_panel_pkg::ctrl_t sel_reg;
  logic wb_acc;
  logic wb_wr;
  assign wb_acc = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_wr  = wb_acc & WB_WE_I;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      sel_reg <= front_panel_pkg::CTRL_ASPECT;
    else if (wb_wr && WB_ADR_I == `FP_OFS_SEL && WB_SEL_I[0] && WB_DAT_I[3:0] < 4'(NCTRL))
      sel_reg <= front_panel_pkg::ctrl_t'(WB_DAT_I[3:0]);
    else if (next_press)
      sel_reg <= (sel_reg == front_panel_pkg::CTRL_AGAIN) ? front_panel_pkg::CTRL_ASPECT
               : front_panel_pkg::ctrl_t'(sel_reg + 4'h1);
    else if (prev_press)
      sel_reg <= (sel_reg == front_panel_pkg::CTRL_ASPECT) ? front_panel_pkg::CTRL_AGAIN
               : front_panel_pkg::ctrl_t'(sel_reg - 4'h1);
  end

  // Arrow handler: a short window lets a partner button join before a single action fires
  front_panel_pkg::arrow_state_t arw_reg;
  logic [31:0] tmr_reg;
  logic [31:0] period_reg;
  logic [3:0]  seen_reg;
  logic        act_step;
  logic        act_reset;
  logic [3:0]  step_dir;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      arw_reg    <= front_panel_pkg::ARW_IDLE;
      tmr_reg    <= 32'h0;
      period_reg <= 32'h0;
      seen_reg   <= 4'h0;
    end
    else
    begin
      tmr_reg <= tmr_reg + 32'h1;
      case (arw_reg)
        front_panel_pkg::ARW_IDLE:
        begin
          seen_reg <= arrows;
          tmr_reg  <= 32'h0;
          if (|arrows)
            arw_reg <= front_panel_pkg::ARW_WAIT;
        end
        front_panel_pkg::ARW_WAIT:
        begin
          seen_reg <= seen_reg | arrows;
          if (!(|arrows))
            arw_reg <= front_panel_pkg::ARW_IDLE;
          else if (tmr_reg >= CHORD_CYC - 1)
          begin
            tmr_reg    <= 32'h0;
            period_reg <= REP_START_CYC;
            arw_reg    <= (chord_lr | chord_ud) ? front_panel_pkg::ARW_LATCH
                        : front_panel_pkg::ARW_HOLD;
          end
        end
        front_panel_pkg::ARW_HOLD:
        begin
          if (!(|arrows))
            arw_reg <= front_panel_pkg::ARW_IDLE;
          else if (chord_lr | chord_ud)
            arw_reg <= front_panel_pkg::ARW_LATCH;
          else if (tmr_reg >= period_reg - 1)
          begin
            tmr_reg <= 32'h0;
            // Each repeat shortens the interval by a quarter, down to a floor
            period_reg <= (period_reg - (period_reg >> 2) < REP_MIN_CYC) ? REP_MIN_CYC
                        : period_reg - (period_reg >> 2);
          end
        end
        front_panel_pkg::ARW_LATCH:
        begin
          if (!(|arrows))
            arw_reg <= front_panel_pkg::ARW_IDLE;
        end
        default:
          arw_reg <= front_panel_pkg::ARW_IDLE;
      endcase
    end
  end

  always_comb
  begin
    act_step  = 1'b0;
    act_reset = 1'b0;
    step_dir  = arrows;
    case (arw_reg)
      front_panel_pkg::ARW_WAIT:
      begin
        // A tap shorter than the chord window still steps once on release
        step_dir  = (|arrows) ? arrows : seen_reg;
        act_step  = !(|arrows) || (tmr_reg >= CHORD_CYC - 1 && !(chord_lr | chord_ud));
        act_reset = (|arrows) && tmr_reg >= CHORD_CYC - 1 && (chord_lr | chord_ud);
      end
      front_panel_pkg::ARW_HOLD:
      begin
        act_reset = (|arrows) && (chord_lr | chord_ud);
        act_step  = (|arrows) && !(chord_lr | chord_ud) && tmr_reg >= period_reg - 1;
      end
      default:
      begin
        act_step  = 1'b0;
        act_reset = 1'b0;
      end
    endcase
  end

  // Region corners; step_dir order is up, down, left, right
  logic [11:0] pos_h_reg;
  logic [11:0] pos_v_reg;
  logic [11:0] size_h_reg;
  logic [11:0] size_v_reg;
  logic on_pos;
  logic on_size;
  assign on_pos  = (sel_reg == front_panel_pkg::CTRL_POS);
  assign on_size = (sel_reg == front_panel_pkg::CTRL_SIZE);

  function automatic logic [11:0] nudge(input logic [11:0] v, input logic inc,
                                        input logic dec, input logic [11:0] lo,
                                        input logic [11:0] hi);
    logic [11:0] r;
    r = v;
    if (inc && v < hi)
      r = v + 12'h1;
    else if (dec && v > lo)
      r = v - 12'h1;
    return r;
  endfunction : nudge

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      pos_h_reg  <= 12'h000;
      pos_v_reg  <= 12'h000;
      size_h_reg <= `FP_H_MAX;
      size_v_reg <= `FP_V_MAX;
    end
    else if (wb_wr && WB_ADR_I == `FP_OFS_POS)
    begin
      pos_h_reg <= WB_DAT_I[`FP_POS_H_LSB +: 12];
      pos_v_reg <= WB_DAT_I[`FP_POS_V_LSB +: 12];
    end
    else if (wb_wr && WB_ADR_I == `FP_OFS_SIZE)
    begin
      size_h_reg <= WB_DAT_I[`FP_POS_H_LSB +: 12];
      size_v_reg <= WB_DAT_I[`FP_POS_V_LSB +: 12];
    end
    else if (act_reset && on_pos)
    begin
      if (chord_lr)
        pos_h_reg <= 12'h000;
      if (chord_ud)
        pos_v_reg <= 12'h000;
    end
    else if (act_reset && on_size)
    begin
      size_h_reg <= `FP_H_MAX;
      size_v_reg <= `FP_V_MAX;
    end
    else if (act_step && on_pos)
    begin
      // Upper-left corner can reach but not pass right of or below the lower-right one
      pos_h_reg <= nudge(pos_h_reg, step_dir[3], step_dir[2], 12'h000, size_h_reg);
      pos_v_reg <= nudge(pos_v_reg, step_dir[1], step_dir[0], 12'h000, size_v_reg);
    end
    else if (act_step && on_size)
    begin
      size_h_reg <= nudge(size_h_reg, step_dir[3], step_dir[2], pos_h_reg, `FP_H_MAX);
      size_v_reg <= nudge(size_v_reg, step_dir[1], step_dir[0], pos_v_reg, `FP_V_MAX);
    end
  end

  // Scalar control values, one generate entry per control
  logic [7:0] val_reg [NCTRL];
  logic [NCTRL-1:0] at_def;

  generate
    for (gi = 0; gi < NCTRL; gi++)
    begin : g_val
      always_ff @(posedge SYS_CLK)
      begin
        if (RST)
          val_reg[gi] <= VAL_DEF[gi];
        else if (wb_wr && WB_ADR_I == 8'(`FP_OFS_VAL_BASE + 4 * gi) && WB_SEL_I[0])
          val_reg[gi] <= (WB_DAT_I[7:0] > VAL_MAX[gi]) ? VAL_MAX[gi] : WB_DAT_I[7:0];
        else if (sel_reg == 4'(gi) && act_reset && chord_lr)
          val_reg[gi] <= VAL_DEF[gi];
        else if (sel_reg == 4'(gi) && act_step && (step_dir[3] | step_dir[1])
                 && val_reg[gi] < VAL_MAX[gi])
          val_reg[gi] <= val_reg[gi] + 8'h1;
        else if (sel_reg == 4'(gi) && act_step && (step_dir[2] | step_dir[0])
                 && val_reg[gi] > 8'h00)
          val_reg[gi] <= val_reg[gi] - 8'h1;
      end
      if (gi == 1)
      begin : g_pos
        assign at_def[gi] = (pos_h_reg == 12'h000) && (pos_v_reg == 12'h000);
      end
      else if (gi == 2)
      begin : g_size
        assign at_def[gi] = (size_h_reg == `FP_H_MAX) && (size_v_reg == `FP_V_MAX);
      end
      else
      begin : g_sc
        assign at_def[gi] = (val_reg[gi] == VAL_DEF[gi]);
      end
    end
  endgenerate

  // Configuration, thresholds and timing offset
  logic        level_b_reg;
  logic        aud_dig_reg;
  logic [15:0] thr_near_reg;
  logic [15:0] thr_peak_reg;
  logic [23:0] timing_reg;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      level_b_reg  <= 1'b0;
      aud_dig_reg  <= 1'b0;
      thr_near_reg <= `FP_THR_NEAR_RST;
      thr_peak_reg <= `FP_THR_PEAK_RST;
      timing_reg   <= 24'h000000;
    end
    else if (wb_wr)
    begin
      if (WB_ADR_I == `FP_OFS_CFG && WB_SEL_I[0])
      begin
        level_b_reg <= WB_DAT_I[`FP_CFG_LEVELB];
        aud_dig_reg <= WB_DAT_I[`FP_CFG_AUDDIG];
      end
      if (WB_ADR_I == `FP_OFS_THRESH)
      begin
        thr_near_reg <= WB_DAT_I[`FP_THR_NEAR_LSB +: 16];
        thr_peak_reg <= WB_DAT_I[`FP_THR_PEAK_LSB +: 16];
      end
      if (WB_ADR_I == `FP_OFS_TIMING)
        timing_reg <= WB_DAT_I[23:0];
    end
  end

  // Blink phase for the selected control
  logic [31:0] blink_cnt_reg;
  logic        blink_reg;
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= 1'b1;
    end
    else if (blink_cnt_reg >= BLINK_CYC - 1)
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg     <= ~blink_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
  end

  // Lamps and routing, all registered
  logic [1:0] mode_v;
  assign mode_v = val_reg[front_panel_pkg::CTRL_MODE][1:0];

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      CTRL_LED_GRN    <= 11'h000;
      CTRL_LED_RED    <= 11'h000;
      STD_NTSC_LED    <= 1'b0;
      STD_PAL_LED     <= 1'b0;
      MODE_LED        <= 3'h0;
      FMT_LED         <= 4'h0;
      AGAIN_LED_GRN   <= 1'b0;
      AGAIN_LED_RED   <= 1'b0;
      LVL_LED_GRN     <= 1'b0;
      LVL_LED_YEL     <= 1'b0;
      LVL_LED_RED     <= 1'b0;
      INPUT_LED       <= 1'b0;
      REF_LED         <= 1'b0;
      SDI2_MIRROR     <= 1'b1;
      CPST_BLACK      <= 1'b0;
      AUD_RIGHT_TO_34 <= 1'b0;
      FREE_RUN        <= 1'b1;
    end
    else
    begin
      for (int i = 0; i < NCTRL; i++)
      begin
        // Green die always lit unless blanked; red die added for orange
        CTRL_LED_GRN[i] <= (sel_reg != 4'(i)) | blink_reg;
        CTRL_LED_RED[i] <= ~at_def[i] & ((sel_reg != 4'(i)) | blink_reg);
      end
      STD_NTSC_LED  <= (val_reg[front_panel_pkg::CTRL_STD][0] == 1'b0);
      STD_PAL_LED   <= (val_reg[front_panel_pkg::CTRL_STD][0] == 1'b1);
      MODE_LED      <= 3'b001 << mode_v;
      FMT_LED       <= 4'b0001 << val_reg[front_panel_pkg::CTRL_FMT][1:0];
      AGAIN_LED_GRN <= 1'b1;
      AGAIN_LED_RED <= ~at_def[front_panel_pkg::CTRL_AGAIN];
      LVL_LED_GRN   <= (AUDIO_LEVEL < thr_near_reg);
      LVL_LED_YEL   <= (AUDIO_LEVEL >= thr_near_reg) && (AUDIO_LEVEL <= thr_peak_reg);
      LVL_LED_RED   <= (AUDIO_LEVEL > thr_peak_reg);
      INPUT_LED     <= INPUT_VALID;
      REF_LED       <= REF_PRESENT & REF_LOCKED;
      // Level B splits the link across both outputs, so mirroring stops
      SDI2_MIRROR   <= ~(level_b_reg && mode_v == front_panel_pkg::MODE_3G);
      CPST_BLACK    <= (mode_v != front_panel_pkg::MODE_SD);
      AUD_RIGHT_TO_34 <= aud_dig_reg;
      FREE_RUN      <= ~(REF_PRESENT & REF_LOCKED);
    end
  end

  assign REGION_X0     = pos_h_reg;
  assign REGION_Y0     = pos_v_reg;
  assign REGION_X1     = size_h_reg;
  assign REGION_Y1     = size_v_reg;
  assign TIMING_OFFSET = timing_reg;

  // Wishbone slave: one wait state, unmapped reads return zero
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0;
    case (WB_ADR_I)
      `FP_OFS_SEL:    rd_data = {28'h0, sel_reg};
      `FP_OFS_POS:    rd_data = {4'h0, pos_v_reg, 4'h0, pos_h_reg};
      `FP_OFS_SIZE:   rd_data = {4'h0, size_v_reg, 4'h0, size_h_reg};
      `FP_OFS_TIMING: rd_data = {8'h0, timing_reg};
      `FP_OFS_CFG:    rd_data = {30'h0, aud_dig_reg, level_b_reg};
      `FP_OFS_THRESH: rd_data = {thr_peak_reg, thr_near_reg};
      `FP_OFS_STATUS: rd_data = {16'h0, AUDIO_LEVEL[15:12], 1'b0, REF_LOCKED, REF_PRESENT,
                                 INPUT_VALID, 2'h0, deb_reg};
      default:
      begin
        for (int i = 0; i < NCTRL; i++)
          if (WB_ADR_I == 8'(`FP_OFS_VAL_BASE + 4 * i))
            rd_data = {24'h0, val_reg[i]};
      end
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end
    else
    begin
      WB_ACK_O <= wb_acc;
      WB_DAT_O <= wb_acc ? rd_data : 32'h0;
    end
  end

endmodule : front_panel_control_logic

// *** fp_panel_asserts.sv ***
// Assertions on front panel bus answers, status lamps and output routing
`timescale 1ns/1ps
module fp_panel_asserts (
  input wire logic        SYS_CLK, RST,                         // Clock, sync reset
  input wire logic        WB_CYC_I, WB_STB_I, WB_ACK_O,         // Bus handshake
  input wire logic [31:0] WB_DAT_O,                             // Read data
  input wire logic        INPUT_VALID, REF_PRESENT, REF_LOCKED, // Status inputs
  input wire logic        INPUT_LED, REF_LED, FREE_RUN,         // Status lamps
  input wire logic [2:0]  MODE_LED,                             // Mode lamps
  input wire logic        CPST_BLACK, SDI2_MIRROR               // Routing flags
);
  logic [1:0] up_cnt; // Lamps lag reset release, so wait before judging them
  logic       live;
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      up_cnt <= 2'h0;
    else if (!live)
      up_cnt <= up_cnt + 2'h1;
  end
  assign live = (up_cnt == 2'h3);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not a one cycle pulse");
  property p_dat; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("read data outside answer");
  property p_in; live |-> INPUT_LED == $past(INPUT_VALID); endproperty
  a_in: assert property (p_in) else $error("input lamp wrong");
  property p_ref; live |-> REF_LED == $past(REF_PRESENT && REF_LOCKED); endproperty
  a_ref: assert property (p_ref) else $error("reference lamp wrong");
  property p_free; live |-> FREE_RUN == !REF_LED; endproperty
  a_free: assert property (p_free) else $error("free run flag wrong");
  property p_mode; live |-> $onehot(MODE_LED); endproperty
  a_mode: assert property (p_mode) else $error("mode lamps not one-hot");
  property p_cpst; live |-> CPST_BLACK == !MODE_LED[0]; endproperty
  a_cpst: assert property (p_cpst) else $error("composite black wrong");
  property p_sdi; live && !MODE_LED[2] |-> SDI2_MIRROR; endproperty
  a_sdi: assert property (p_sdi) else $error("outputs differ outside 3G");
  cover property (WB_ACK_O);
  cover property (live && !SDI2_MIRROR);
  cover property (live && REF_LED);
endmodule : fp_panel_asserts

bind front_panel_control_logic fp_panel_asserts i_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .INPUT_VALID(INPUT_VALID),
  .REF_PRESENT(REF_PRESENT), .REF_LOCKED(REF_LOCKED), .INPUT_LED(INPUT_LED),
  .REF_LED(REF_LED), .FREE_RUN(FREE_RUN), .MODE_LED(MODE_LED),
  .CPST_BLACK(CPST_BLACK), .SDI2_MIRROR(SDI2_MIRROR));

// *** fp_operator.sv ***
// Operator pressing the panel buttons, with contact bounce on every change
`timescale 1ns/1ps
module fp_operator (
  input  wire logic       clk,  // Panel clock
  input  wire logic [5:0] want, // Buttons meant held: prev,next,up,down,left,right
  output logic      [5:0] btn   // Contact levels
);
  logic [5:0] held = 6'h0; // Intent seen last cycle
  logic [5:0] chg  = 6'h0; // Buttons that just changed
  logic [1:0] bnc  = 2'h0; // Bounce cycles left
  initial btn = 6'h0;
  always_ff @(posedge clk)
  begin
    held <= want;
    if (want != held)
      chg <= want ^ held;
    bnc <= (want != held) ? 2'h3 : ((bnc != 2'h0) ? bnc - 2'h1 : 2'h0);
    btn <= bnc[0] ? want ^ chg : want;
  end
endmodule : fp_operator

// *** tb.sv ***
// Self-checking bench for the front panel control logic
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        iv = 1'b0, rp = 1'b0, rl = 1'b0, ack, ntsc, pal, ared, lg, ly, lr;
  logic        inl, refl, frun, mir, blk, a34, ag;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic [15:0] lvl = 16'h0;
  logic [5:0]  want = 6'h0, btn;
  logic [10:0] grn, red;
  logic [2:0]  mled;
  logic [3:0]  fled, sel = 4'hf;
  logic [11:0] x0, y0, x1, y1;
  logic [23:0] tofs;
  int          n_errors = 0, checks_done = 0;
  front_panel_control_logic #(.DEBOUNCE_CYC(8), .CHORD_CYC(20), .REP_START_CYC(40),
    .REP_MIN_CYC(8), .BLINK_CYC(16)) i_dut (
    .SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .BTN_PREV(btn[5]), .BTN_NEXT(btn[4]), .BTN_UP(btn[3]), .BTN_DOWN(btn[2]),
    .BTN_LEFT(btn[1]), .BTN_RIGHT(btn[0]), .INPUT_VALID(iv), .REF_PRESENT(rp),
    .REF_LOCKED(rl), .AUDIO_LEVEL(lvl), .CTRL_LED_GRN(grn), .CTRL_LED_RED(red),
    .STD_NTSC_LED(ntsc), .STD_PAL_LED(pal), .MODE_LED(mled), .FMT_LED(fled),
    .AGAIN_LED_GRN(ag), .AGAIN_LED_RED(ared), .LVL_LED_GRN(lg), .LVL_LED_YEL(ly),
    .LVL_LED_RED(lr), .INPUT_LED(inl), .REF_LED(refl), .SDI2_MIRROR(mir),
    .CPST_BLACK(blk), .AUD_RIGHT_TO_34(a34), .FREE_RUN(frun), .REGION_X0(x0),
    .REGION_Y0(y0), .REGION_X1(x1), .REGION_Y1(y1), .TIMING_OFFSET(tofs));
  fp_operator i_op (.clk(clk), .want(want), .btn(btn));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++t < 20);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (t >= 20)
      n_errors++;
  endtask : wb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdchk
  task automatic settle;
    repeat (2) @(posedge clk);
  endtask : settle
  task automatic press(input logic [5:0] b, input int n);
    want <= b;
    repeat (n) @(posedge clk);
    want <= 6'h0;
    repeat (60) @(posedge clk);
  endtask : press
  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    final_report();
  end
  initial
  begin
    int k;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    chk({x0, y0, x1, y1}, {24'h0, 12'h77f, 12'h4af});
    chk({tofs, frun}, {24'h0, 1'b1});
    rdchk(8'h14, 32'h78006000);
    rdchk(8'h20, 32'h0);
    press(6'h20, 20);
    rdchk(8'h00, 32'ha);
    press(6'h10, 20);
    rdchk(8'h00, 32'h0);
    sel <= 4'he;
    wb(1'b1, 8'h00, 32'h1);
    sel <= 4'hf;
    wb(1'b1, 8'h00, 32'hb);
    rdchk(8'h00, 32'h0);
    k = 0;
    repeat (40) @(posedge clk) k += (grn[0] === 1'b1);
    chk(k > 0 && k < 40, 1);
    $display("selection test done");
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b1, 8'h04, 32'h00100010);
    press(6'h01, 45);
    chk(x0, 12'h011);
    press(6'h02, 45);
    press(6'h04, 45);
    chk({x0, y0}, {12'h010, 12'h011});
    press(6'h01, 400);
    chk(x0 > 12'h01c, 1);
    press(6'h03, 45);
    chk(x0, 12'h0);
    press(6'h0c, 45);
    chk(y0, 12'h0);
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b1, 8'h08, 32'h01000100);
    chk({x1, y1}, {12'h100, 12'h100});
    press(6'h0c, 45);
    chk({x1, y1}, {12'h77f, 12'h4af});
    $display("arrow test done");
    wb(1'b1, 8'h50, 32'h10);
    chk({grn[4], red[4]}, 2'b11);
    wb(1'b1, 8'h50, 32'h80);
    chk({grn[4], red[4]}, 2'b10);
    wb(1'b1, 8'h68, 32'h81);
    chk({ag, ared}, 2'b11);
    for (int m = 0; m < 4; m++)
    begin
      wb(1'b1, 8'h5c, m);
      wb(1'b1, 8'h60, m);
      wb(1'b1, 8'h58, m & 1);
      chk(fled, 4'h1 << m);
      chk({ntsc, pal}, (m & 1) ? 2'b01 : 2'b10);
      if (m < 3)
        chk({mled, blk}, {3'h1 << m, m != 0});
    end
    lvl <= 16'h1000;
    wb(1'b1, 8'h10, 32'h3);
    chk({mir, a34}, 2'b01);
    chk({lg, ly, lr}, 3'b100);
    lvl <= 16'h7000;
    settle();
    chk({lg, ly, lr}, 3'b010);
    lvl <= 16'h7900;
    settle();
    chk({lg, ly, lr}, 3'b001);
    iv <= 1'b1;
    rp <= 1'b1;
    settle();
    chk({inl, refl, frun}, 3'b101);
    rl <= 1'b1;
    settle();
    chk({inl, refl, frun}, 3'b110);
    rdchk(8'h18, 32'h7700);
    wb(1'b1, 8'h0c, 32'h123456);
    chk(tofs, 24'h123456);
    $display("lamp test done");
    final_report();
  end
endmodule : tb
